// *** sacc_pkg.sv ***
// Constants shared by the converter control block: timing, register map and field layout.
// Assumes a 20 MHz system clock and a converter clock made internally or taken from a pin.
//
// Functional notes
// [R1] A conversion lasts 19 or 20 rising converter clock edges.
// [R2] A start within 30 ns before a converter edge gives the full 20 edges.
// [R3] Track/hold enters hold at conversion start; convert-start rising edge in first mode.
// [R4] A start from device select holds on the falling edge of device select.
// [R5] At the end of each conversion track/hold returns to tracking.
// [R6] First mode: a convert-start pulse starts conversion and hold.
// [R7] Second mode is chosen by the host holding convert-start low.
// [R8] Second mode: select plus read starts conversion; status keeps host waiting until done.
// [R9] Serial-only variant accepts starts from convert-start only; the code also accepts the software start from the control register.
// [R10] Format select high gives only the 14-bit parallel format.
// [R11] Format select low gives byte and serial formats.
// [R12] In byte/serial use three top pins serve serial, the fourth selects byte; the code gives these their own ports and drives bits 13..8 low.
// [R13] Every output format works in either start mode.
// [R14] Parallel format drives all 14 bits together, MSB on bit 13.
// [R15] Byte format needs two host reads per result.
// [R16] Byte read with byte select low gives the low eight bits.
// [R17] Byte select high gives upper six bits right aligned, top two zero.
// [R18] Result is twos-complement, one step is full scale over 16384.
// [R19] Largest code is 01 1111 1111 1111, smallest is 10 0000 0000 0000.
// [R20] Host may invert the MSB for straight binary in unipolar use.
// [R21] At 2 MHz converter clock throughput stays within 12 us.
// [R22] Continuous select keeps the serial clock running between transfers.
// [R23] First mode: status rests high and drops low at conversion end.
// [R24] Second mode: status low from start until completion.
// [R25] Data bus is driven only while select and read are both asserted.

package sacc_pkg;

  localparam int unsigned MCLK_HZ        = 20_000_000;
  localparam int unsigned CONV_CLK_HZ    = 2_000_000;
  localparam int unsigned CLK_DIV        = MCLK_HZ / CONV_CLK_HZ;
  localparam int unsigned MCLK_PERIOD_NS = 1_000_000_000 / MCLK_HZ;

  localparam int unsigned START_GUARD_NS  = 30;
  localparam int unsigned GUARD_CYC_RAW   = (START_GUARD_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int unsigned START_GUARD_CYC = (GUARD_CYC_RAW < 1) ? 1 : GUARD_CYC_RAW;

  localparam int unsigned ACQ_NS  = 2_000;
  localparam int unsigned ACQ_CYC = (ACQ_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

  localparam int unsigned RES_W       = 14;
  localparam int unsigned CONV_EDGES  = 19;
  localparam int unsigned FIRST_BIT_EDGE = 2;
  localparam int unsigned SER_LEAD    = 2;

  localparam logic [3:0]  ADDR_CTRL   = 4'h0;
  localparam logic [3:0]  ADDR_STATUS = 4'h4;
  localparam logic [3:0]  ADDR_RESULT = 4'h8;

  localparam int unsigned CTRL_CLK_EXT     = 0;
  localparam int unsigned CTRL_SERIAL_ONLY = 1;
  localparam int unsigned CTRL_SW_START    = 2;
  localparam logic [1:0]  CTRL_RESET       = 2'h0;

  localparam int unsigned ST_CONVERTING = 0;
  localparam int unsigned ST_EOC        = 1;
  localparam int unsigned ST_MODE2      = 2;
  localparam int unsigned ST_ACQUIRING  = 3;
  localparam int unsigned ST_PARALLEL   = 4;

  localparam logic [RES_W-1:0] RESULT_RESET = 14'h0000;

  typedef enum logic [1:0] {SACC_IDLE, SACC_CONV, SACC_ACQ} sacc_state_t;

endpackage

// *** sacc_top.sv ***
// Conversion control of a 14-bit successive-approximation converter with a parallel,
// byte and serial host side. Host pins are synchronous to mclk; the analog DAC and
// comparator sit outside, driven by dac_code and answered by cmp_above.
//
// Chosen here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module sacc_top
  import sacc_pkg::*;
(
  // Clock and reset.
  input  wire logic              mclk,
  input  wire logic              rstn,
  // Avalon-MM slave.
  input  wire logic [3:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  // Host start and read pins.
  input  wire logic              convert_start_n,
  input  wire logic              cs_n,
  input  wire logic              rd_n,
  input  wire logic              upper_byte_select,
  input  wire logic              format_parallel,
  input  wire logic              sclk_continuous,
  input  wire logic              ext_conv_clk,
  // Parallel data bus; oe_n low while driving.
  output logic      [RES_W-1:0]  data_out,
  output logic                   data_oe_n,
  // Status pin: end of conversion in first mode, busy in second.
  output logic                   conv_status,
  // Open-drain serial pins; oe_n low pulls the line low.
  output logic                   ser_strobe_oe_n,
  output logic                   ser_clk_oe_n,
  output logic                   ser_data_oe_n,
  // Analog side.
  output logic                   track_hold,
  output logic      [RES_W-1:0]  dac_code,
  input  wire logic              cmp_above
);

  sacc_state_t      state_r;
  logic [3:0]       div_r;
  logic             ext_prev_r;
  logic             csrd_prev_r;
  logic             cvst_prev_r;
  logic [1:0]       ctrl_r;
  logic             sw_start_r;
  logic             guard_r;
  logic [4:0]       edge_cnt_r;
  logic [6:0]       acq_cnt_r;
  logic [RES_W-1:0] sar_r;
  logic [RES_W-1:0] result_r;
  logic             eoc_r;
  logic             mode2_r;
  logic [15:0]      ser_sh_r;
  logic             int_half_r;

  logic             conv_edge;
  logic             csrd_low;
  logic             read_fall;
  logic             start_mode1;
  logic             start_mode2;
  logic             start_evt;
  logic             bit_edge;
  logic [3:0]       bit_idx;
  logic             done_edge;

  // Internal converter clock divides mclk by ten to 2 MHz: 20 edges take 10 us and the
  // 2 us acquisition afterwards keeps a full cycle inside 12 us.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      div_r <= 4'h0;
    else if (div_r == 4'(CLK_DIV - 1))
      div_r <= 4'h0; // see [R21]
    else
      div_r <= div_r + 4'h1;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      // Edge detectors rest at the idle level of their pins, so no false edge follows reset.
      ext_prev_r  <= 1'b0;
      csrd_prev_r <= 1'b0;
      cvst_prev_r <= 1'b1;
      int_half_r  <= 1'b0;
    end
    else
    begin
      ext_prev_r  <= ext_conv_clk;
      csrd_prev_r <= csrd_low;
      cvst_prev_r <= convert_start_n;
      // Serial clock phase: high in the second half of each internal converter period.
      int_half_r  <= (div_r >= 4'(CLK_DIV / 2));
    end
  end

  // The external clock is sampled, so its rising edges are seen up to one mclk late.
  assign conv_edge = ctrl_r[CTRL_CLK_EXT] ? (ext_conv_clk && !ext_prev_r)
                                          : (div_r == 4'h0);
  assign csrd_low  = !cs_n && !rd_n;
  assign read_fall = csrd_low && !csrd_prev_r;

  // Second mode is recognised by convert-start sitting low; a rising edge leaves it.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      mode2_r <= 1'b0;
    else if (!convert_start_n && !cvst_prev_r)
      mode2_r <= 1'b1; // see [R7]
    else if (convert_start_n)
      mode2_r <= 1'b0;
  end

  assign start_mode1 = (convert_start_n && !cvst_prev_r) || sw_start_r; // see [R6]
  // The select edge is used so that hold is taken as select falls, with read already low.
  assign start_mode2 = mode2_r && !ctrl_r[CTRL_SERIAL_ONLY] && read_fall
                       && (format_parallel || !upper_byte_select); // see [R8] see [R9]
  // Starts are accepted in any format; a second pulse mid-conversion is ignored.
  assign start_evt   = (state_r != SACC_CONV) && (start_mode1 || start_mode2); // see [R13]

  assign bit_edge  = conv_edge && !guard_r && (edge_cnt_r >= 5'(FIRST_BIT_EDGE - 1))
                     && (edge_cnt_r < 5'(FIRST_BIT_EDGE - 1 + RES_W));
  // Counted edge 2 decides bit 13 and counted edge 15 decides bit 0.
  assign bit_idx   = 4'(RES_W + FIRST_BIT_EDGE - 2) - edge_cnt_r[3:0];
  // The edge counter keeps its last value after a conversion, so done is tied to the
  // conversion state; otherwise every later converter edge would set the flag again.
  assign done_edge = conv_edge && !guard_r && (state_r == SACC_CONV)
                     && (edge_cnt_r == 5'(CONV_EDGES - 1));

  // Conversion sequencer.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r    <= SACC_IDLE;
      guard_r    <= 1'b0;
      edge_cnt_r <= 5'h00;
      acq_cnt_r  <= 7'h00;
    end
    else
    begin
      case (state_r)
        SACC_IDLE, SACC_ACQ:
        begin
          if (start_evt)
          begin
            state_r    <= SACC_CONV;
            edge_cnt_r <= 5'h00;
            // A converter edge falling inside the guard after the start is not counted,
            // which stretches that conversion to the full 20 edges.
            guard_r    <= 1'(START_GUARD_CYC); // see [R2]
          end
          // Acquisition is timed so that STATUS shows when the input has settled again.
          else if (state_r == SACC_ACQ)
          begin
            if (acq_cnt_r == 7'(ACQ_CYC - 1))
              state_r <= SACC_IDLE;
            acq_cnt_r <= acq_cnt_r + 7'h01;
          end
        end
        SACC_CONV:
        begin
          guard_r <= 1'b0;
          if (done_edge)
          begin
            state_r   <= SACC_ACQ; // see [R1]
            acq_cnt_r <= 7'h00;
          end
          else if (conv_edge && !guard_r)
            edge_cnt_r <= edge_cnt_r + 5'h01; // see [R1]
        end
        default:
          state_r <= SACC_IDLE;
      endcase
    end
  end

  // Track/hold: hold from the start event until the conversion ends.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      track_hold <= 1'b0;
    else if (start_evt)
      track_hold <= 1'b1; // see [R3] see [R4]
    else if (done_edge)
      track_hold <= 1'b0; // see [R5]
  end

  // Successive approximation in straight binary; the DAC sees the trial code.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      sar_r    <= RESULT_RESET;
      dac_code <= RESULT_RESET;
    end
    else if (start_evt)
    begin
      sar_r    <= RESULT_RESET;
      dac_code <= {1'b1, {(RES_W-1){1'b0}}};
    end
    // A bit stays set only where the held input reaches the trial code.
    else if (bit_edge)
    begin
      sar_r[bit_idx]    <= cmp_above;
      dac_code[bit_idx] <= cmp_above;
      if (bit_idx != 4'h0)
        dac_code[bit_idx - 4'h1] <= 1'b1;
    end
  end

  // Twos-complement result: straight binary with the MSB inverted, so full code spans
  // 01 1111 1111 1111 down to 10 0000 0000 0000 in 16384 steps.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      result_r <= RESULT_RESET;
    else if (done_edge)
      result_r <= {~sar_r[RES_W-1], sar_r[RES_W-2:0]}; // see [R18] see [R19] see [R20]
  end

  // Status pin. End-of-conversion flag wins over a read that clears it in the same cycle.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      eoc_r <= 1'b0;
    else if (done_edge)
      eoc_r <= 1'b1;
    else if (read_fall)
      eoc_r <= 1'b0;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      conv_status <= 1'b1;
    else if (mode2_r)
      conv_status <= !((state_r == SACC_CONV && !done_edge) || start_evt); // see [R24] see [R8]
    else
      conv_status <= !(eoc_r || done_edge) || (read_fall && !done_edge); // see [R23]
  end

  // Parallel and byte output. Byte format drives bits 13..8 low; the serial pins and byte select
  // have their own ports. Each byte needs its own read.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      data_out  <= RESULT_RESET;
      data_oe_n <= 1'b1;
    end
    else
    begin
      data_oe_n <= !csrd_low; // see [R25]
      if (format_parallel)
        data_out <= done_edge ? {~sar_r[RES_W-1], sar_r[RES_W-2:0]} : result_r; // see [R10] see [R14]
      else if (upper_byte_select)
        data_out <= {6'h00, 2'h0, result_r[RES_W-1:8]}; // see [R17] see [R15]
      else
        data_out <= {6'h00, result_r[7:0]}; // see [R16] see [R11]
    end
  end

  // Serial word: two leading zeros then the result MSB first, shifted on converter edges
  // during conversion. Bits are sent as decided, so no extra buffer is needed.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      ser_sh_r <= 16'h0000;
    else if (start_evt)
      ser_sh_r <= 16'h0000;
    else if (bit_edge)
      ser_sh_r[15 - SER_LEAD - (RES_W - 1 - 32'(bit_idx))] <= cmp_above ^ (bit_idx == 4'(RES_W - 1));
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      ser_strobe_oe_n <= 1'b1;
      ser_clk_oe_n    <= 1'b1;
      ser_data_oe_n   <= 1'b1;
    end
    else if (format_parallel)
    begin
      ser_strobe_oe_n <= 1'b1;
      ser_clk_oe_n    <= 1'b1;
      ser_data_oe_n   <= 1'b1;
    end
    else
    begin
      ser_strobe_oe_n <= !(state_r == SACC_CONV); // see [R12]
      // Noncontinuous clock releases its pin when the transfer is over.
      ser_clk_oe_n    <= (sclk_continuous || state_r == SACC_CONV) ? int_half_r : 1'b1; // see [R22]
      ser_data_oe_n   <= (state_r == SACC_CONV) ? 
                         ser_sh_r[15 - (edge_cnt_r[3:0] & 4'hf)] : 1'b1;
    end
  end

  // Avalon-MM slave: every access waits one cycle, then completes with waitrequest low.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
      ctrl_r          <= CTRL_RESET;
      sw_start_r      <= 1'b0;
    end
    else
    begin
      sw_start_r <= 1'b0;
      if ((avs_read || avs_write) && avs_waitrequest)
      begin
        avs_waitrequest <= 1'b0;
        case (avs_address)
          ADDR_CTRL:   avs_readdata <= {30'h0000_0000, ctrl_r};
          ADDR_STATUS: avs_readdata <= {27'h000_0000, format_parallel,
                                        state_r == SACC_ACQ, mode2_r, eoc_r,
                                        state_r == SACC_CONV};
          ADDR_RESULT: avs_readdata <= {18'h0_0000, result_r};
          default:     avs_readdata <= 32'h0000_0000;
        endcase
      end
      else
      begin
        avs_waitrequest <= 1'b1;
        // The write lands at the edge that shows waitrequest low, while the master holds it.
        if (avs_write && !avs_waitrequest && avs_address == ADDR_CTRL)
        begin
          ctrl_r     <= avs_writedata[1:0];
          sw_start_r <= avs_writedata[CTRL_SW_START];
        end
      end
    end
  end

endmodule

`default_nettype wire

// *** sacc_top_assertions.sv ***
// Checker for the converter control block: bus handshake, hold timing, status and outputs.
// Assumes a converter clock edge every 10 mclk and a host that holds byte select during reads.
`timescale 1ns/10ps
`default_nettype none
module sacc_top_assertions
  import sacc_pkg::*;
(
  // Clock, reset and register bus.
  input wire logic             mclk,
  input wire logic             rstn,
  input wire logic [3:0]       avs_address,
  input wire logic             avs_read,
  input wire logic             avs_write,
  input wire logic [31:0]      avs_readdata,
  input wire logic             avs_waitrequest,
  // Host pins.
  input wire logic             convert_start_n,
  input wire logic             cs_n,
  input wire logic             rd_n,
  input wire logic             upper_byte_select,
  input wire logic             format_parallel,
  // Outputs.
  input wire logic [RES_W-1:0] data_out,
  input wire logic             data_oe_n,
  input wire logic             conv_status,
  input wire logic             ser_strobe_oe_n,
  input wire logic             ser_clk_oe_n,
  input wire logic             ser_data_oe_n,
  input wire logic             track_hold
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic [8:0] hold_cnt_r;
  // The hold length spans far more cycles than a repetition may, so it is counted here.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      hold_cnt_r <= 9'h000;
    else if (track_hold)
      hold_cnt_r <= hold_cnt_r + 9'h001;
    else
      hold_cnt_r <= 9'h000;
  end
  hold_start_a: assert property (
    $rose(convert_start_n) && !track_hold |-> ##[1:2] track_hold)
    else $error("no hold after convert start");
  hold_len_a: assert property (
    $fell(track_hold) |-> hold_cnt_r inside {[9'h0B2:9'h0CA]})
    else $error("conversion length out of range");
  eoc_low_a: assert property (
    $fell(track_hold) && convert_start_n |-> ##[0:2] !conv_status)
    else $error("no end of conversion flag");
  busy_a: assert property (
    $rose(track_hold) && !convert_start_n |-> ##[0:1] !conv_status)
    else $error("busy not low at start");
  busy_end_a: assert property (
    $fell(track_hold) && !convert_start_n |-> ##[0:2] conv_status)
    else $error("busy not released");
  bus_drive_a: assert property (data_oe_n == $past(cs_n || rd_n))
    else $error("data bus enable wrong");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus access not answered");
  byte_upper_a: assert property (
    !data_oe_n && !format_parallel && upper_byte_select && $past(upper_byte_select)
    |-> data_out[13:6] == 8'h00) else $error("upper byte not aligned");
  serial_off_a: assert property (
    format_parallel && $past(format_parallel)
    |-> ser_strobe_oe_n && ser_clk_oe_n && ser_data_oe_n) else $error("serial pins active");
  cover property ($fell(track_hold) && !convert_start_n);
  cover property (!data_oe_n && !format_parallel && upper_byte_select);
  cover property (!avs_waitrequest && $past(avs_write));
endmodule
bind sacc_top sacc_top_assertions i_sacc_top_assertions (.mclk, .rstn, .avs_address, .avs_read,
  .avs_write, .avs_readdata, .avs_waitrequest, .convert_start_n, .cs_n, .rd_n, .upper_byte_select,
  .format_parallel, .data_out, .data_oe_n, .conv_status, .ser_strobe_oe_n, .ser_clk_oe_n,
  .ser_data_oe_n, .track_hold);
`default_nettype wire

// *** sacc_far_end.sv ***
// Far side of the block: the sampled analog level, the comparator and the host's view of the bus.
// Assumes the trial code is straight binary and a released bus has no pull resistor.
`timescale 1ns/10ps
`default_nettype none
module sacc_far_end
  import sacc_pkg::*;
(
  // Clock and level to convert.
  input  wire logic             mclk,
  input  wire logic [RES_W-1:0] vin,
  // Converter side.
  input  wire logic             track_hold,
  input  wire logic [RES_W-1:0] dac_code,
  output logic                  cmp_above,
  // Parallel bus as the host sees it.
  input  wire logic [RES_W-1:0] data_out,
  input  wire logic             data_oe_n,
  output logic      [RES_W-1:0] bus_level
);
  logic [RES_W-1:0] held_r;
  logic [RES_W-1:0] last_r;
  always_ff @(posedge mclk)
  begin
    if (!track_hold)
      held_r <= vin;
    if (!data_oe_n)
      last_r <= data_out;
  end
  // Straight binary trial code, so the twos-complement result is the input with its top bit flipped.
  assign cmp_above = (held_r >= dac_code);
  // A released bus shows the inverse of the last value so that stale data cannot pass as fresh.
  assign bus_level = data_oe_n ? ~last_r : data_out;
endmodule
`default_nettype wire

// *** sacc_top_tb.sv ***
// Self-checking bench for the converter control block with its far-side model.
// Assumes the package constants for the register map and a 2 MHz external converter clock.
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module sacc_top_tb;
  import sacc_pkg::*;
  logic mclk, rstn, avs_read, avs_write, avs_waitrequest, convert_start_n, cs_n, rd_n;
  logic upper_byte_select, format_parallel, sclk_continuous, ext_conv_clk, data_oe_n;
  logic conv_status, ser_strobe_oe_n, ser_clk_oe_n, ser_data_oe_n, track_hold, cmp_above;
  logic st_mid, th_mid;
  logic [3:0] avs_address;
  logic [2:0] div_r;
  logic [31:0] avs_writedata, avs_readdata;
  logic [RES_W-1:0] data_out, dac_code, vin, bus_level;
  int bad_count = 0;
  int check_count = 0;
  sacc_top i_sacc_top (.mclk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .convert_start_n, .cs_n, .rd_n, .upper_byte_select,
    .format_parallel, .sclk_continuous, .ext_conv_clk, .data_out, .data_oe_n, .conv_status,
    .ser_strobe_oe_n, .ser_clk_oe_n, .ser_data_oe_n, .track_hold, .dac_code, .cmp_above);
  sacc_far_end i_sacc_far_end (.mclk, .vin, .track_hold, .dac_code, .cmp_above, .data_out,
    .data_oe_n, .bus_level);
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // External converter clock toggles every 5 mclk, giving 2 MHz.
  always @(posedge mclk)
  begin
    div_r <= (div_r == 3'h4) ? 3'h0 : div_r + 3'h1;
    if (div_r == 3'h4)
      ext_conv_clk <= ~ext_conv_clk;
  end
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge mclk);
    avs_write <= wr;
    avs_read <= !wr;
    avs_address <= adr;
    avs_writedata <= wd;
    // Only the watchdog ends a wait for the slave.
    do
      @(posedge mclk);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // A status level that does not come within 400 mclk, about two conversions, ends the run as a failure.
  task automatic wait_status(input logic lvl);
    int n;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (conv_status !== lvl && n < 400);
    if (conv_status !== lvl)
    begin
      bad_count++;
      print_verdict();
    end
  endtask
  task automatic pulse();
    @(posedge mclk);
    convert_start_n <= 1'b0;
    @(posedge mclk);
    convert_start_n <= 1'b1;
    wait_status(1'b0);
  endtask
  // Read as a host would: in the second mode this same read starts and waits out a conversion.
  task automatic host_read(input logic ubs, output logic [RES_W-1:0] d);
    @(posedge mclk);
    upper_byte_select <= ubs;
    @(posedge mclk);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    repeat (3) @(posedge mclk);
    st_mid = conv_status;
    th_mid = track_hold;
    wait_status(1'b1);
    repeat (2) @(posedge mclk);
    d = bus_level;
    cs_n <= 1'b1;
    rd_n <= 1'b1;
  endtask
  task automatic t_regs();
    logic [31:0] r;
    logic [RES_W-1:0] d;
    bus(1'b0, 4'hC, 32'h0000_0000, r);
    `CHK(r, 32'h0000_0000)
    bus(1'b0, ADDR_STATUS, 32'h0000_0000, r);
    `CHK(r[ST_PARALLEL], 1'b1)
    vin <= 14'h3001;
    bus(1'b1, ADDR_CTRL, 32'h0000_0005, r);
    wait_status(1'b0);
    bus(1'b0, ADDR_RESULT, 32'h0000_0000, r);
    `CHK(r[13:0], 14'h1001)
    host_read(1'b0, d);
    `CHK(d, 14'h1001)
    bus(1'b0, ADDR_CTRL, 32'h0000_0000, r);
    `CHK(r[1:0], 2'h1)
    bus(1'b1, ADDR_CTRL, 32'h0000_0000, r);
    repeat (50) @(posedge mclk);
  endtask
  task automatic t_mode1();
    logic [RES_W-1:0] d;
    logic [RES_W-1:0] vals [3] = '{14'h3FFF, 14'h0000, 14'h1234};
    foreach (vals[i])
    begin
      vin <= vals[i];
      pulse();
      repeat (20) @(posedge mclk);
      `CHK(conv_status, 1'b0)
      `CHK(dac_code, vals[i])
      host_read(1'b0, d);
      `CHK(d, vals[i] ^ 14'h2000)
      `CHK(conv_status, 1'b1)
      repeat (50) @(posedge mclk);
    end
  endtask
  task automatic t_byte();
    logic [RES_W-1:0] d;
    logic [4:0] lows;
    format_parallel <= 1'b0;
    vin <= 14'h2ABC;
    @(posedge mclk);
    convert_start_n <= 1'b0;
    @(posedge mclk);
    convert_start_n <= 1'b1;
    repeat (40) @(posedge mclk);
    `CHK(ser_strobe_oe_n, 1'b0)
    wait_status(1'b0);
    repeat (2) @(posedge mclk);
    `CHK(ser_strobe_oe_n, 1'b1)
    // The clock pin stays released after the frame unless it is set to run on.
    lows = 5'h00;
    repeat (20)
    begin
      @(posedge mclk);
      lows = lows + 5'(!ser_clk_oe_n);
    end
    `CHK(lows, 5'h00)
    sclk_continuous <= 1'b1;
    repeat (2) @(posedge mclk);
    lows = 5'h00;
    repeat (20)
    begin
      @(posedge mclk);
      lows = lows + 5'(!ser_clk_oe_n);
    end
    `CHK(lows, 5'(CLK_DIV))
    sclk_continuous <= 1'b0;
    host_read(1'b1, d);
    `CHK(d, 14'h000A)
    host_read(1'b0, d);
    `CHK(d, 14'h00BC)
    format_parallel <= 1'b1;
    repeat (50) @(posedge mclk);
  endtask
  task automatic t_mode2();
    logic [31:0] r;
    logic [RES_W-1:0] d;
    vin <= 14'h0155;
    convert_start_n <= 1'b0;
    bus(1'b1, ADDR_CTRL, 32'h0000_0002, r);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    repeat (5) @(posedge mclk);
    `CHK(track_hold, 1'b0)
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    bus(1'b1, ADDR_CTRL, 32'h0000_0000, r);
    host_read(1'b0, d);
    `CHK(st_mid, 1'b0)
    `CHK(th_mid, 1'b1)
    `CHK(d, 14'h2155)
  endtask
  initial
  begin
    {rstn, avs_read, avs_write, avs_address, avs_writedata} = '0;
    {convert_start_n, cs_n, rd_n, format_parallel} = 4'hF;
    {upper_byte_select, sclk_continuous, ext_conv_clk, div_r, vin} = '0;
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    repeat (2) @(posedge mclk);
    t_regs();
    t_mode1();
    t_byte();
    t_mode2();
    print_verdict();
  end
  initial
  begin
    #(50 * 20000);
    bad_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
